// File: inc/uhep_pkg.sv
package uhep_pkg;
   // register index space: 0..15 endpoints, then control registers
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int NUM_EP = 16;
   localparam logic [ADDR_W-1:0] EP_BASE_IDX = 5'h00;
   localparam logic [ADDR_W-1:0] MAIN_CTRL_IDX = 5'h10;
   localparam logic [ADDR_W-1:0] OTG_CTRL_IDX = 5'h11;
   localparam logic [ADDR_W-1:0] STATUS_IDX = 5'h12;

   // endpoint register fields
   localparam int EP_HSHK_BIT = 0;
   localparam int EP_STALL_BIT = 1;
   localparam int EP_TXEN_BIT = 2;
   localparam int EP_RXEN_BIT = 3;
   localparam int EP_CONDIS_BIT = 4;
   localparam int EP_NAK_RETRY_DISABLE_BIT = 6;
   localparam int EP_LOW_SPEED_DIRECT_ENABLE_BIT = 7;
   localparam int EP_UNUSED_BIT = 5;
   localparam logic [7:0] EP_RESET = 8'h00;

   // control register fields
   localparam int HOST_EN_BIT = 3;
   localparam int OTG_EN_BIT = 2;
   localparam int DM_PD_BIT = 4;
   localparam int DP_PD_BIT = 5;
   // line status word fields
   localparam int STAT_DP_BIT = 0;
   localparam int STAT_DM_BIT = 1;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

   // token/handshake events from the link engine
   typedef enum logic [1:0] {
      UHEP_TOK_OUT = 2'b00,
      UHEP_TOK_IN = 2'b01,
      UHEP_TOK_SETUP = 2'b10,
      UHEP_TOK_NONE = 2'b11
   } uhep_tok_e;

   typedef struct packed {
      logic valid;
      logic [3:0] ep;
      uhep_tok_e tok;
   } uhep_tok_s;

   typedef struct packed {
      logic low_speed_direct_enable;
      logic retry_dis;
      logic condis;
      logic rxen;
      logic txen;
      logic stall;
      logic hshk;
   } uhep_ep_s;

   typedef struct packed {
      logic allow;
      logic handshake;
      logic retry_dis;
      logic low_speed;
   } uhep_verdict_s;
endpackage

// File: logic/uhep_pulldown.sv
module uhep_pulldown
   import uhep_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // control
   input wire logic host_mode_enable_i,
   input wire logic otg_operation_enable_i,
   input wire logic dplus_pulldown_enable_i,
   input wire logic dminus_pulldown_enable_i,
   // pull-down drive
   output logic dplus_pulldown_o,
   output logic dminus_pulldown_o
);
   typedef struct packed {
      logic dp;
      logic dm;
   } uhep_pd_s;

   uhep_pd_s st_ff;
   uhep_pd_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (otg_operation_enable_i) begin
         nxt_st.dp = dplus_pulldown_enable_i;
         nxt_st.dm = dminus_pulldown_enable_i;
      end else begin
         nxt_st.dp = host_mode_enable_i;
         nxt_st.dm = host_mode_enable_i;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dplus_pulldown_o = st_ff.dp;
   assign dminus_pulldown_o = st_ff.dm;
endmodule

// File: logic/uhep_verdict.sv
module uhep_verdict
   import uhep_pkg::*;
(
   // endpoint settings and token
   input wire uhep_ep_s ep_i,
   input wire uhep_tok_e tok_i,
   // decision
   output uhep_verdict_s verdict_o
);
   always_comb begin
      verdict_o = '0;
      verdict_o.handshake = ep_i.hshk;
      verdict_o.retry_dis = ep_i.retry_dis;
      verdict_o.low_speed = ep_i.low_speed_direct_enable;
      case (tok_i)
         UHEP_TOK_SETUP: begin
            // setup needs both directions and control not disabled
            verdict_o.allow = ep_i.txen && ep_i.rxen && !ep_i.condis;
         end
         UHEP_TOK_IN: begin
            verdict_o.allow = ep_i.txen;
         end
         UHEP_TOK_OUT: begin
            verdict_o.allow = ep_i.rxen;
         end
         default: begin
            verdict_o.allow = 1'b0;
         end
      endcase
   end
endmodule

// File: logic/uhep_top.sv
// The strobed register port and the address map were left to the implementer.
module uhep_top
   import uhep_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // token from the link engine
   input wire uhep_tok_s token_i,
   input wire logic stall_seen_i,
   // decision back to the link engine
   output uhep_verdict_s verdict_o,
   output logic verdict_valid_o,
   // line pull-downs
   output logic dplus_pulldown_o,
   output logic dminus_pulldown_o
);

   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [NUM_EP-1:0][7:0] ep;
      logic host_mode_enable;
      logic otg_operation_enable;
      logic dplus_pulldown_enable;
      logic dminus_pulldown_enable;
      logic [DATA_W-1:0] rdata;
      uhep_verdict_s verdict;
      logic verdict_valid;
   } uhep_state_s;

   uhep_state_s st_ff;
   uhep_state_s nxt_st;
   uhep_ep_s tok_ep;
   uhep_verdict_s tok_verdict;

   function automatic logic is_ep_addr(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1] == EP_BASE_IDX[ADDR_W-1];
   endfunction

   // shared by the write and read paths so the maps cannot drift apart
   function automatic logic is_main_addr(input logic [ADDR_W-1:0] a);
      return a == MAIN_CTRL_IDX;
   endfunction

   function automatic logic is_otg_addr(input logic [ADDR_W-1:0] a);
      return a == OTG_CTRL_IDX;
   endfunction

   function automatic logic is_status_addr(input logic [ADDR_W-1:0] a);
      return a == STATUS_IDX;
   endfunction

   // register image of one endpoint, with host-only bits masked
   function automatic logic [7:0] ep_view(input logic [7:0] r,
                                          input logic is_ep0,
                                          input logic host);
      logic [7:0] v;
      v = r;
      if (!(is_ep0 && host)) begin
         v[EP_LOW_SPEED_DIRECT_ENABLE_BIT] = 1'b0;
         v[EP_NAK_RETRY_DISABLE_BIT] = 1'b0;
      end
      v[EP_UNUSED_BIT] = 1'b0;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // decode the addressed endpoint for the link engine
   always_comb begin
      logic [7:0] r;
      r = ep_view(st_ff.ep[token_i.ep], token_i.ep == 4'h0,
                  st_ff.host_mode_enable);
      tok_ep.low_speed_direct_enable = r[EP_LOW_SPEED_DIRECT_ENABLE_BIT];
      tok_ep.retry_dis = r[EP_NAK_RETRY_DISABLE_BIT];
      tok_ep.condis = r[EP_CONDIS_BIT];
      tok_ep.rxen = r[EP_RXEN_BIT];
      tok_ep.txen = r[EP_TXEN_BIT];
      tok_ep.stall = r[EP_STALL_BIT];
      tok_ep.hshk = r[EP_HSHK_BIT];
   end

   uhep_verdict u_verdict (
      .ep_i(tok_ep),
      .tok_i(token_i.tok),
      .verdict_o(tok_verdict)
   );

   uhep_pulldown u_pulldown (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .host_mode_enable_i(st_ff.host_mode_enable),
      .otg_operation_enable_i(st_ff.otg_operation_enable),
      .dplus_pulldown_enable_i(st_ff.dplus_pulldown_enable),
      .dminus_pulldown_enable_i(st_ff.dminus_pulldown_enable),
      .dplus_pulldown_o(dplus_pulldown_o),
      .dminus_pulldown_o(dminus_pulldown_o)
   );

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [3:0] widx;
      logic [7:0] wv;
      widx = reg_addr_i[3:0];
      wv = reg_wdata_i[7:0];
      nxt_st = st_ff;
      nxt_st.verdict_valid = token_i.valid && token_i.tok != UHEP_TOK_NONE;
      nxt_st.verdict = token_i.valid ? tok_verdict : '0;

      // software writes
      if (reg_write_i) begin
         if (is_ep_addr(reg_addr_i)) begin
            // unused bit 5 and host-only bits on ep1..15 stay zero
            nxt_st.ep[widx] = ep_view(wv, widx == 4'h0, 1'b1);
         end else if (is_main_addr(reg_addr_i)) begin
            nxt_st.host_mode_enable = reg_wdata_i[HOST_EN_BIT];
         end else if (is_otg_addr(reg_addr_i)) begin
            nxt_st.otg_operation_enable = reg_wdata_i[OTG_EN_BIT];
            nxt_st.dplus_pulldown_enable = reg_wdata_i[DP_PD_BIT];
            nxt_st.dminus_pulldown_enable = reg_wdata_i[DM_PD_BIT];
         end
      end

      // stall event wins over a same-cycle software clear
      if (token_i.valid && stall_seen_i) begin
         nxt_st.ep[token_i.ep][EP_STALL_BIT] = 1'b1;
      end

      // read data stands one cycle after the strobe only
      nxt_st.rdata = '0;
      if (reg_read_i) begin
         if (is_ep_addr(reg_addr_i)) begin
            nxt_st.rdata = {8'h00, ep_view(st_ff.ep[widx], widx == 4'h0,
                                           st_ff.host_mode_enable)};
         end else if (is_main_addr(reg_addr_i)) begin
            nxt_st.rdata[HOST_EN_BIT] = st_ff.host_mode_enable;
         end else if (is_otg_addr(reg_addr_i)) begin
            nxt_st.rdata[OTG_EN_BIT] = st_ff.otg_operation_enable;
            nxt_st.rdata[DP_PD_BIT] = st_ff.dplus_pulldown_enable;
            nxt_st.rdata[DM_PD_BIT] = st_ff.dminus_pulldown_enable;
         end else if (is_status_addr(reg_addr_i)) begin
            nxt_st.rdata[STAT_DP_BIT] = dplus_pulldown_o;
            nxt_st.rdata[STAT_DM_BIT] = dminus_pulldown_o;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata_o = st_ff.rdata;
   assign verdict_o = st_ff.verdict;
   assign verdict_valid_o = st_ff.verdict_valid;
endmodule

// File: verification/uhep_top_asserts.sv
module uhep_top_asserts
   import uhep_pkg::*;
(
   // watched ports
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [DATA_W-1:0] reg_rdata_o,
   input wire uhep_tok_s token_i,
   input wire logic stall_seen_i,
   input wire uhep_verdict_s verdict_o,
   input wire logic verdict_valid_o,
   input wire logic dplus_pulldown_o,
   input wire logic dminus_pulldown_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (reset_i);
   logic [DATA_W-1:0] main_ff;
   logic [DATA_W-1:0] otg_ff;
   logic exp_dp;
   logic exp_dm;
   // shadow of the mode registers, moved only by writes
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         main_ff <= CTRL_RESET;
         otg_ff <= CTRL_RESET;
      end else if (reg_write_i && reg_addr_i == MAIN_CTRL_IDX) begin
         main_ff <= reg_wdata_i;
      end else if (reg_write_i && reg_addr_i == OTG_CTRL_IDX) begin
         otg_ff <= reg_wdata_i;
      end
   end
   assign exp_dp = otg_ff[OTG_EN_BIT] ? otg_ff[DP_PD_BIT]
                                      : main_ff[HOST_EN_BIT];
   assign exp_dm = otg_ff[OTG_EN_BIT] ? otg_ff[DM_PD_BIT]
                                      : main_ff[HOST_EN_BIT];
   sequence s_stall;
      token_i.valid && stall_seen_i;
   endsequence
   sequence s_rd_stalled;
      reg_read_i && reg_addr_i == {1'b0, $past(token_i.ep, 2)};
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // a lag of up to two edges is tolerated on the pull-downs
   pd_plus_a: assert property (
      $past(exp_dp, 2) == exp_dp && $past(exp_dp) == exp_dp
      |-> dplus_pulldown_o == exp_dp) else $error("bad d+ pull-down");
   pd_minus_a: assert property (
      $past(exp_dm, 2) == exp_dm && $past(exp_dm) == exp_dm
      |-> dminus_pulldown_o == exp_dm) else $error("bad d- pull-down");
   rd_idle_a: assert property (
      !reg_read_i |=> reg_rdata_o == 16'h0000) else $error("stray data");
   rd_unmapped_a: assert property (
      reg_read_i && reg_addr_i > STATUS_IDX |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   ep_reserved_a: assert property (
      reg_read_i && reg_addr_i < MAIN_CTRL_IDX
      |=> reg_rdata_o[15:8] == 8'h00 && !reg_rdata_o[EP_UNUSED_BIT])
      else $error("reserved endpoint bits set");
   ep_upper_a: assert property (
      reg_read_i && reg_addr_i != EP_BASE_IDX && reg_addr_i < MAIN_CTRL_IDX
      |=> reg_rdata_o[7:6] == 2'b00) else $error("ep0-only bits set");
   verdict_pulse_a: assert property (
      verdict_valid_o == $past(token_i.valid && token_i.tok != UHEP_TOK_NONE))
      else $error("verdict pulse wrong");
   stall_sticks_a: assert property (
      s_stall ##1 !reg_write_i ##1 s_rd_stalled |=> reg_rdata_o[EP_STALL_BIT])
      else $error("stall flag missing");
endmodule

bind uhep_top uhep_top_asserts chk(.clock_i, .reset_i, .reg_addr_i,
   .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .token_i,
   .stall_seen_i, .verdict_o, .verdict_valid_o, .dplus_pulldown_o,
   .dminus_pulldown_o);

// File: verification/uhep_link_model.sv
module uhep_link_model
   import uhep_pkg::*;
(
   // clock
   input wire logic clock_i,
   // token toward the block
   output uhep_tok_s token_o,
   output logic stall_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      token_o = '{1'b0, 4'hF, UHEP_TOK_NONE};
      stall_o = 1'b0;
   end
   // idle fields flip so a stale token cannot pass for a fresh one
   task automatic send(input logic [3:0] ep, input uhep_tok_e t,
                       input logic st);
      @(posedge clock_i);
      token_o <= '{1'b1, ep, t};
      stall_o <= st;
      @(posedge clock_i);
      token_o <= '{1'b0, ~ep, UHEP_TOK_NONE};
      stall_o <= ~st;
   endtask
endmodule

// File: verification/tb_top.sv
module tb_top import uhep_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i, reset_i, reg_write_i, reg_read_i, stall_seen_i;
   logic verdict_valid_o, dplus_pulldown_o, dminus_pulldown_o;
   logic [4:0] reg_addr_i;
   logic [3:0] n4;
   logic [15:0] reg_wdata_i, reg_rdata_o, w, d, e;
   uhep_tok_s token_i;
   uhep_verdict_s verdict_o;
   int mismatches, checks;
   uhep_top dut(.clock_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
      .reg_read_i, .reg_rdata_o, .token_i, .stall_seen_i, .verdict_o,
      .verdict_valid_o, .dplus_pulldown_o, .dminus_pulldown_o);
   uhep_link_model link(.clock_i, .token_o(token_i), .stall_o(stall_seen_i));
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      #1 w = reg_rdata_o;
   endtask
   task automatic pd(input logic [1:0] x);
      repeat (3) @(posedge clock_i);
      #1 check({14'h0, dplus_pulldown_o, dminus_pulldown_o}, {14'h0, x});
   endtask
   function automatic logic [15:0] ep_exp(input logic z, input logic [15:0] v,
                                          input logic host);
      ep_exp = {8'h00, (z && host) ? v[7:6] : 2'b00, 1'b0, v[4:0]};
   endfunction
   function automatic logic ok(input logic [15:0] c, input uhep_tok_e t);
      case (t)
         UHEP_TOK_SETUP: ok = c[EP_TXEN_BIT] & c[EP_RXEN_BIT]
                              & !c[EP_CONDIS_BIT];
         UHEP_TOK_IN: ok = c[EP_TXEN_BIT];
         default: ok = c[EP_RXEN_BIT];
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {reset_i, reg_write_i, reg_read_i} = 3'b100;
      reg_addr_i = 5'h00;
      reg_wdata_i = 16'h0000;
      mismatches = 0;
      checks = 0;
      w = 16'($urandom(32'hB727));
      repeat (20) @(posedge clock_i);
      reset_i <= 1'b0;
      for (int a = 0; a < 32; a++) begin
         rd(a[4:0]);
         check(w, 16'h0000);
      end
      wr(5'h19, 16'hFFFF);
      rd(5'h19);
      check(w, 16'h0000);
      for (int n = 15; n >= 0; n--) begin
         d = 16'($urandom) & 16'hFFFD;
         wr(n[4:0], d);
         rd(n[4:0]);
         check(w, ep_exp(n == 0, d, 1'b0));
      end
      wr(MAIN_CTRL_IDX, 16'h0008);
      rd(EP_BASE_IDX);
      check(w, ep_exp(1'b1, d, 1'b1));
      pd(2'b11);
      rd(STATUS_IDX);
      check(w, 16'h0003);
      wr(OTG_CTRL_IDX, 16'h0024);
      pd(2'b10);
      wr(OTG_CTRL_IDX, 16'h0014);
      pd(2'b01);
      // every tx/rx/control-disable mix for each of the OUT, IN and SETUP tokens
      for (int i = 0; i < 48; i++) begin
         n4 = i[0] ? 4'h0 : 4'($urandom_range(15, 1));
         d = 16'($urandom & 8'hC1) | {11'h0, i[3:1], 2'b00};
         wr({1'b0, n4}, d);
         link.send(n4, uhep_tok_e'(i / 16), 1'b0);
         e = {11'h0, 1'b1, ok(d, uhep_tok_e'(i / 16)), d[0],
              n4 == 4'h0 && d[6], n4 == 4'h0 && d[7]};
         #1 check({11'h0, verdict_valid_o, verdict_o}, e);
      end
      link.send(4'h5, UHEP_TOK_IN, 1'b1);
      rd(5'h05);
      check(w & 16'h0002, 16'h0002);
      link.send(4'h5, UHEP_TOK_OUT, 1'b0);
      rd(5'h05);
      check(w & 16'h0002, 16'h0002);
      wr(5'h05, 16'h0000);
      rd(5'h05);
      check(w, 16'h0000);
      // clear and stall event in one cycle: the event must win
      fork
         wr(5'h05, 16'h0000);
         link.send(4'h5, UHEP_TOK_IN, 1'b1);
      join
      rd(5'h05);
      check(w, 16'h0002);
      // a token of no kind earns no verdict
      link.send(4'h3, UHEP_TOK_NONE, 1'b0);
      #1 check({15'h0, verdict_valid_o}, 16'h0000);
      // reset in mid-run clears registers and pull-downs
      @(posedge clock_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      #1 check({14'h0, dplus_pulldown_o, dminus_pulldown_o}, 16'h0000);
      rd(OTG_CTRL_IDX);
      check(w, CTRL_RESET);
      rd(EP_BASE_IDX);
      check(w, {8'h00, EP_RESET});
      results();
   end
   initial begin
      #200000;
      mismatches++;
      results();
   end
endmodule
